// [rtl/tws_pkg.sv]
// Shared constants, types and register layout of the three-wire serial port.
package tws_pkg;

    // ==========================================================
    // Register map and field layout
    // ==========================================================
    localparam logic [15:0] TWS_MODE_ADDR  = 16'hFFB0;  // Mode register address.
    localparam logic [15:0] TWS_SHIFT_ADDR = 16'hFFB2;  // Shift buffer address.
    localparam logic [7:0]  TWS_MODE_RST   = 8'h00;     // Mode register after reset.
    localparam logic [7:0]  TWS_MODE_WMASK = 8'h87;     // Writable mode bits.
    localparam int          TWS_EN_BIT     = 7;         // Port enable bit.
    localparam int          TWS_RXO_BIT    = 2;         // Receive-only mode bit.
    localparam int          TWS_WORD_BITS  = 8;         // Bits per transfer.
    localparam int          TWS_FIFO_DEPTH = 16;        // Received-word buffer depth.

    // ==========================================================
    // Clock selection codes and half-period counts
    // ==========================================================
    localparam logic [1:0] TWS_CLK_EXT  = 2'h0;  // External clock on the clock pin.
    localparam logic [1:0] TWS_CLK_D64  = 2'h1;  // System clock divided by 64.
    localparam logic [1:0] TWS_CLK_D128 = 2'h2;  // System clock divided by 128.
    localparam logic [7:0] TWS_HALF_D64  = 8'h1F;  // 32 cycles per half period, minus one.
    localparam logic [7:0] TWS_HALF_D128 = 8'h3F;  // 64 cycles per half period, minus one.
    localparam logic [7:0] TWS_HALF_D256 = 8'h7F;  // 128 cycles per half period, minus one.

    // ==========================================================
    // Types
    // ==========================================================
    // Transfer sequencer states, one-hot.
    typedef enum logic [2:0] {
        TWS_IDLE = 3'b001,
        TWS_WAIT = 3'b010,
        TWS_RUN  = 3'b100
    } tws_state_e;

    // One CPU access, held for a single cycle.
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } tws_cpu_req_s;

    // Driven side of the serial pins; enables are low while driving.
    typedef struct packed {
        logic sck_out;
        logic sck_oe_n;
        logic so_out;
        logic so_oe_n;
    } tws_pins_s;

endpackage : tws_pkg

// [rtl/tws_serial_port.sv]
// Three-wire synchronous serial port with its received-word buffer.
//
// Contract
// - Eight-bit shift register converts parallel and serial.
// - Most significant bit always travels first.
// - Enable clear stops shifting, clears counter, frees pins.
// - Mode zero: buffer write starts full-duplex transfer.
// - Mode one: buffer read starts receive, output low.
// - Clock select: external, divide 64, 128, 256.
// - Shift on falling edge, drive output latch.
// - Sample serial input on rising edge.
// - After eight bits stop and set done flag.
// - Start only after end with clock high.
// - Write while disabled never starts a transfer.
// - Reset clears mode register, disabling the port.
// - Unused input or output pin stays free.
// - Each transfer moves exactly eight bits.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Received-word FIFO with a registered output slot
// ==========================================================
module tws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // The pointers wrap naturally, so only powers of two are served.
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("tws_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
    logic [AW-1:0]    wr_ptr;       // Next slot to fill.
    logic [AW-1:0]    rd_ptr;       // Next slot to drain.
    logic [AW:0]      count;        // Words held in storage.

    wire push = in_valid & in_ready;                         // Word accepted.
    wire pop  = (count != '0) & (~out_valid | out_ready);    // Word moved to output slot.

    // The output slot is a flop so the port data never comes through a mux.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr   <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
            end
            count     <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
            in_ready  <= (count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop}) < (AW + 1)'(DEPTH);
            out_valid <= pop | (out_valid & ~out_ready);
        end
    end

    // Storage has no reset; only written slots are ever read.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // The filling side never sees ready while storage is full.
    a_fifo_full_ready : assert property (@(posedge ref_clk) disable iff (!nrst)
        (count == (AW + 1)'(DEPTH)) |-> !in_ready)
        else $error("FIFO shows ready while full");

endmodule : tws_fifo

// ==========================================================
// Serial port top
// ==========================================================
module tws_serial_port
    import tws_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    input  wire tws_pkg::tws_cpu_req_s cpu_req,
    output logic               [7:0] cpu_rdata,
    input  wire logic                sck_in,
    input  wire logic                si_in,
    output tws_pkg::tws_pins_s       pins,
    output logic                     transfer_done_flag,
    input  wire logic                flag_clear,
    output logic                     rx_valid,
    input  wire logic                rx_ready,
    output logic               [7:0] rx_data
);
    import tws_pkg::*;

    // Half-period count of the internal divider for a clock code.
    function automatic logic [7:0] half_count(input logic [1:0] sel);
        case (sel)
            TWS_CLK_D64:  half_count = TWS_HALF_D64;
            TWS_CLK_D128: half_count = TWS_HALF_D128;
            default:      half_count = TWS_HALF_D256;
        endcase
    endfunction : half_count

    // ==========================================================
    // State
    // ==========================================================
    logic [7:0] serial_port_mode;    // Mode register.
    logic [7:0] serial_shift_buffer; // Shift register.
    tws_state_e state;               // Transfer sequencer.
    tws_state_e next_state;          // Sequencer next state.
    logic [3:0] bit_cnt;             // Rising edges seen this transfer.
    logic [7:0] div_cnt;             // Internal clock divider.
    logic       sck_int;             // Internal serial clock level.
    logic       sck_prev;            // Clock pin level one cycle ago.
    logic       so_latch;            // Output latch for the serial-out pin.
    logic       fifo_in_ready;       // Buffer has room for a word.

    // ==========================================================
    // Decoding
    // ==========================================================
    wire       port_enable_bit   = serial_port_mode[TWS_EN_BIT];
    wire       rx_only           = serial_port_mode[TWS_RXO_BIT];
    wire [1:0] clk_sel           = serial_port_mode[1:0];
    wire       ext_clk           = (clk_sel == TWS_CLK_EXT);
    wire       sel_mode          = (cpu_req.addr == TWS_MODE_ADDR);
    wire       sel_shift         = (cpu_req.addr == TWS_SHIFT_ADDR);
    wire       running           = (state == TWS_RUN);
    wire       idle              = (state == TWS_IDLE);
    // Writes during a run are dropped so a stray access cannot corrupt the word.
    wire       shift_wr          = cpu_req.wr & sel_shift & !running;
    wire       trig_wr           = shift_wr & port_enable_bit & !rx_only;
    wire       trig_rd           = cpu_req.rd & sel_shift & port_enable_bit & rx_only & idle;
    wire       trigger           = (trig_wr | trig_rd) & idle;
    // A new run needs the clock line high after the last one.
    wire       clock_high        = ext_clk ? sck_in : sck_int;
    wire       int_tick          = (div_cnt == half_count(clk_sel));
    wire       fall_evt          = running & (ext_clk ? (sck_prev & ~sck_in) : (int_tick & sck_int));
    wire       rise_evt          = running & (ext_clk ? (~sck_prev & sck_in) : (int_tick & ~sck_int));
    wire       last_rise         = rise_evt & (bit_cnt == 4'(TWS_WORD_BITS - 1));
    wire [7:0] rx_word           = {serial_shift_buffer[7:1], si_in};
    wire [7:0] next_rdata        = sel_mode ? (serial_port_mode & TWS_MODE_WMASK) :
                                   sel_shift ? serial_shift_buffer : 8'h00;

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Starts wait for buffer room so no received word is ever lost.
    always_comb begin
        next_state = state;
        case (state)
            TWS_IDLE: begin
                if (trigger) begin
                    next_state = TWS_WAIT;
                end
            end
            TWS_WAIT: begin
                if (fifo_in_ready && clock_high) begin
                    next_state = TWS_RUN;
                end
            end
            TWS_RUN: begin
                if (last_rise) begin
                    next_state = TWS_IDLE;
                end
            end
            default: next_state = TWS_IDLE;
        endcase
        if (!port_enable_bit) begin
            next_state = TWS_IDLE;
        end
    end

    // Mode register, sequencer and bit counter.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            serial_port_mode <= TWS_MODE_RST;
            state            <= TWS_IDLE;
            bit_cnt          <= 4'h0;
        end else begin
            if (cpu_req.wr && sel_mode) begin
                serial_port_mode <= cpu_req.wdata & TWS_MODE_WMASK;
            end
            state   <= next_state;
            // The count restarts on the eighth rise so an idle port never shows a stale eight.
            bit_cnt <= (!port_enable_bit || !running || last_rise) ? 4'h0 : bit_cnt + {3'h0, rise_evt};
        end
    end

    // Internal clock: idles high, toggles every half period while running.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt  <= 8'h00;
            sck_int  <= 1'b1;
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= sck_in;
            // Dropping the enable parks the clock high at once, so an aborted run
            // never leaves the line low while the sequencer is already idle.
            if (!running || ext_clk || !port_enable_bit) begin
                div_cnt <= 8'h00;
                sck_int <= 1'b1;
            end else if (int_tick) begin
                div_cnt <= 8'h00;
                sck_int <= ~sck_int;
            end else begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end

    // Shift register: loads on write, shifts on falls, fills on rises.
    // It has no reset, its content after reset is undefined by design.
    always_ff @(posedge ref_clk) begin
        if (shift_wr) begin
            serial_shift_buffer <= cpu_req.wdata;
        end else if (fall_evt) begin
            serial_shift_buffer <= {serial_shift_buffer[6:0], 1'b0};
        end else if (rise_evt) begin
            serial_shift_buffer <= rx_word;
        end
    end

    // Output latch, done flag, read data and pin drive.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            so_latch           <= 1'b0;
            transfer_done_flag <= 1'b0;
            cpu_rdata          <= 8'h00;
            pins               <= '{sck_out: 1'b1, sck_oe_n: 1'b1, so_out: 1'b0, so_oe_n: 1'b1};
        end else begin
            if (fall_evt) begin
                so_latch <= serial_shift_buffer[7];
            end
            // A completion in the clearing cycle wins over the clear.
            transfer_done_flag <= last_rise | (transfer_done_flag & ~flag_clear);
            if (cpu_req.rd) begin
                cpu_rdata <= next_rdata;
            end
            pins.sck_out  <= sck_int;
            pins.sck_oe_n <= !(port_enable_bit && !ext_clk);
            pins.so_out   <= rx_only ? 1'b0 : so_latch;
            pins.so_oe_n  <= !(port_enable_bit && !rx_only);
        end
    end

    // ==========================================================
    // Received-word buffer
    // ==========================================================
    tws_fifo #(
        .WIDTH (8),
        .DEPTH (TWS_FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_valid  (last_rise),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ==========================================================
    // Assertions
    // ==========================================================
    a_disable_frees_pins : assert property (@(posedge ref_clk) disable iff (!nrst)
        !port_enable_bit |=> pins.sck_oe_n && pins.so_oe_n && bit_cnt == 4'h0)
        else $error("Disabled port still drives pins or counts");

    a_write_starts_run : assert property (@(posedge ref_clk) disable iff (!nrst)
        (trig_wr && idle && fifo_in_ready && !ext_clk) |=> ##1 running)
        else $error("Write in transmit mode did not start a transfer");

    a_rxonly_out_low : assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_only |=> !pins.so_out && pins.so_oe_n)
        else $error("Serial out not low in receive-only mode");

    // A low phase lasts 32 cycles; a disable in mid-phase may park the clock high early.
    a_div_half_period : assert property (@(posedge ref_clk) disable iff (!nrst)
        (running && !ext_clk && $fell(sck_int) && clk_sel == TWS_CLK_D64)
        |-> (!sck_int || !port_enable_bit) [*8] ##25 (sck_int || !running))
        else $error("Divide-by-64 half period wrong");

    a_done_after_eight : assert property (@(posedge ref_clk) disable iff (!nrst)
        last_rise |=> transfer_done_flag && idle)
        else $error("Eighth bit did not end the transfer");

    a_no_start_disabled : assert property (@(posedge ref_clk) disable iff (!nrst)
        (cpu_req.wr && sel_shift && !port_enable_bit) |=> !running)
        else $error("Write while disabled started a transfer");

    a_mode_reserved_zero : assert property (@(posedge ref_clk) disable iff (!nrst)
        serial_port_mode[6:3] == 4'h0)
        else $error("Reserved mode bits not zero");

    a_idle_clock_high : assert property (@(posedge ref_clk) disable iff (!nrst)
        !running |-> sck_int && bit_cnt == 4'h0)
        else $error("Internal clock not high while idle");

    a_count_bounded : assert property (@(posedge ref_clk) disable iff (!nrst)
        running |-> bit_cnt < 4'(TWS_WORD_BITS))
        else $error("Bit counter passed eight");

    c_duplex_done : cover property (@(posedge ref_clk) disable iff (!nrst)
        last_rise && !rx_only);
    c_rxonly_done : cover property (@(posedge ref_clk) disable iff (!nrst)
        last_rise && rx_only);
    c_wait_on_full : cover property (@(posedge ref_clk) disable iff (!nrst)
        state == TWS_WAIT && !fifo_in_ready);

endmodule : tws_serial_port

`default_nettype wire

// [verification/tws_peer_model.sv]
// Behavioural serial peripheral facing the port's clock, serial-in and serial-out pins.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Peripheral model
// ==========================================================
module tws_peer_model (
    input  wire logic       ref_clk,
    input  wire logic       sck_pin,
    input  wire logic       so_pin,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    input  wire logic       ext_go,
    input  wire logic [7:0] ext_half,
    output logic            si_out,
    output logic            ext_sck,
    output logic      [7:0] rx_byte,
    output logic      [3:0] rises,
    output logic      [7:0] low_len
);
    logic       sck_d;  // Clock pin level one cycle ago, for edge detection.
    logic [7:0] lcnt;   // Cycles spent low in the present low phase.
    logic [4:0] ecnt;   // External clock half periods still to make.
    logic [7:0] hcnt;   // Cycles left in the present external half period.
    logic [2:0] hold;   // Hold time left after the last rising edge.
    initial begin
        si_out = 1'b0; ext_sck = 1'b1; sck_d = 1'b1; lcnt = 8'h00; ecnt = 5'h00;
        hcnt = 8'h00; hold = 3'h0; rx_byte = 8'h00; rises = 4'h0; low_len = 8'h00;
    end
    // A fall puts the next bit out, a rise takes one in; once the hold time
    // after the last bit has run out the line toggles so no stale value lingers.
    always @(posedge ref_clk) begin
        sck_d <= sck_pin;
        lcnt  <= sck_pin ? 8'h00 : lcnt + 8'h01;
        if (hold != 3'h0) hold <= hold - 3'h1;
        else if (rises == 4'h8) si_out <= ~si_out;
        if (load) begin
            rises <= 4'h0; rx_byte <= 8'h00; low_len <= 8'h00;
        end else if (sck_d && !sck_pin && rises < 4'h8) begin
            si_out <= tx_byte[3'h7 - rises[2:0]];
        end else if (!sck_d && sck_pin) begin
            rx_byte <= {rx_byte[6:0], so_pin};
            rises   <= rises + 4'h1;
            if (rises == 4'h0) low_len <= lcnt;
            hold <= 3'h7;
        end
    end
    // External clock: eight low-high cycles per request, then parked high.
    always @(posedge ref_clk) begin
        if (ext_go) begin
            ecnt <= 5'd15; hcnt <= ext_half; ext_sck <= 1'b0;
        end else if (ecnt != 5'h00) begin
            if (hcnt == 8'h01) begin
                ext_sck <= ~ext_sck; ecnt <= ecnt - 5'h01; hcnt <= ext_half;
            end else hcnt <= hcnt - 8'h01;
        end
    end
endmodule : tws_peer_model
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking testbench of the three-wire serial port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tws_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic         ref_clk, nrst, flag, flag_clear, rx_valid, rx_ready;
    logic   [7:0] cpu_rdata, rx_data, tx_byte, rx_byte, low_len;
    tws_cpu_req_s cpu_req;   // CPU access driven at the falling edge.
    tws_pins_s    pins;      // Driven side of the serial pins.
    logic         load, ext_go, si, ext_sck;
    logic   [3:0] rises;     // Rising clock edges seen by the peripheral.
    logic  [31:0] seed = 32'hCB2824D2;
    int           fail_count = 0, n_tests = 0;
    logic   [7:0] exp_q[$];  // Words the port should have received, in order.
    // A released serial-out line is pulled high; a released clock line shows the peripheral's clock.
    wire sck_pin = pins.sck_oe_n ? ext_sck : pins.sck_out;
    wire so_pin  = pins.so_oe_n ? 1'b1 : pins.so_out;
    tws_serial_port u_tws_serial_port (.ref_clk(ref_clk), .nrst(nrst), .cpu_req(cpu_req),
        .cpu_rdata(cpu_rdata), .sck_in(sck_pin), .si_in(si), .pins(pins), .transfer_done_flag(flag),
        .flag_clear(flag_clear), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
    tws_peer_model u_tws_peer_model (.ref_clk(ref_clk), .sck_pin(sck_pin), .so_pin(so_pin),
        .load(load), .tx_byte(tx_byte), .ext_go(ext_go), .ext_half(8'h08), .si_out(si),
        .ext_sck(ext_sck), .rx_byte(rx_byte), .rises(rises), .low_len(low_len));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13); seed = seed ^ (seed >> 17); seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // One CPU access; the strobe stands for one cycle, read data is settled on return.
    task automatic cpu(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(negedge ref_clk);
        cpu_req.addr = a; cpu_req.wr = w; cpu_req.rd = !w; cpu_req.wdata = d;
        @(negedge ref_clk);
        cpu_req.wr = 1'b0; cpu_req.rd = 1'b0;
    endtask : cpu
    task automatic pulse_load(input logic [7:0] b);
        @(negedge ref_clk); tx_byte = b; load = 1'b1;
        @(negedge ref_clk); load = 1'b0;
    endtask : pulse_load
    // Drain the buffer against the model while the consumer stalls at random.
    task automatic drain();
        int n; logic r;
        n = 0;
        while (exp_q.size() > 0 && n < 2000) begin
            @(negedge ref_clk); n++;
            r = 1'(rnd() >> 9);
            rx_ready = r;
            if (r && rx_valid) chk(rx_data, exp_q.pop_front(), "received word");
        end
        @(negedge ref_clk); rx_ready = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(8'(exp_q.size()), 8'h00, "words left");
        chk(rx_valid, 1'b0, "buffer empty");
    endtask : drain
    // One transfer under the given mode; stall means the buffer is full at the trigger.
    task automatic xfer(input logic [7:0] mode, input bit stall);
        logic [7:0] tx, pb; int n; logic so_free;
        tx = 8'(rnd()); pb = 8'(rnd()); so_free = 1'b1;
        pulse_load(pb);
        cpu(TWS_MODE_ADDR, 1'b1, mode);
        cpu(TWS_SHIFT_ADDR, !mode[2], tx);
        if (stall) begin
            repeat (100) @(negedge ref_clk);
            chk(rises, 4'h0, "start held without room");
            drain();
        end
        repeat (5) @(negedge ref_clk);
        if (mode[1:0] == 2'h0) begin
            ext_go = 1'b1; @(negedge ref_clk); ext_go = 1'b0;
        end
        n = 0;
        while (flag !== 1'b1 && n < 3000) begin
            @(negedge ref_clk); n++;
            if (pins.so_oe_n !== 1'b1) so_free = 1'b0;
        end
        // The clock pin and the peripheral's last edge lag the flag by up to two cycles.
        repeat (3) @(negedge ref_clk);
        chk(flag, 1'b1, "done flag");
        chk(rises, 4'h8, "clock cycles");
        chk(sck_pin, 1'b1, "clock idle level");
        chk(pins.sck_oe_n, mode[1:0] == 2'h0, "clock drive");
        if (mode[2]) begin
            chk(so_free, 1'b1, "output pin free");
            chk(pins.so_out, 1'b0, "output low");
        end else chk(rx_byte, tx, "sent word");
        if (mode[1:0] != 2'h0) chk(low_len, 8'd32 << (mode[1:0] - 2'h1), "half period");
        exp_q.push_back(pb);
        @(negedge ref_clk); flag_clear = 1'b1;
        @(negedge ref_clk); flag_clear = 1'b0;
        chk(flag, 1'b0, "flag cleared");
        $display("test done: transfer mode %h", mode);
    endtask : xfer
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        cpu_req = '0; flag_clear = 1'b0; rx_ready = 1'b0; load = 1'b0; ext_go = 1'b0;
        tx_byte = 8'h00; nrst = 1'b0;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        cpu(TWS_MODE_ADDR, 1'b0, 8'h00);
        chk(cpu_rdata, 8'h00, "mode after reset");
        chk({6'h00, pins.sck_oe_n, pins.so_oe_n}, 8'h03, "pins free");
        cpu(TWS_MODE_ADDR, 1'b1, 8'hFF);
        cpu(TWS_MODE_ADDR, 1'b0, 8'h00);
        chk(cpu_rdata, 8'h87, "mode readback");
        cpu(16'hFFB4, 1'b0, 8'h00);
        chk(cpu_rdata, 8'h00, "unmapped read");
        $display("test done: registers");
        // A write while stopped must not start once the port is enabled.
        pulse_load(8'h00);
        cpu(TWS_MODE_ADDR, 1'b1, 8'h01);
        cpu(TWS_SHIFT_ADDR, 1'b1, 8'(rnd()));
        cpu(TWS_MODE_ADDR, 1'b1, 8'h81);
        repeat (300) @(negedge ref_clk);
        chk(rises, 4'h0, "no start");
        chk(flag, 1'b0, "no flag");
        // Disabling in mid-transfer aborts without a flag or a word.
        cpu(TWS_SHIFT_ADDR, 1'b1, 8'(rnd()));
        repeat (100) @(negedge ref_clk);
        cpu(TWS_MODE_ADDR, 1'b1, 8'h00);
        repeat (300) @(negedge ref_clk);
        chk(flag, 1'b0, "abort flag");
        chk(pins.sck_oe_n, 1'b1, "abort clock free");
        $display("test done: disabled and abort");
        // Seventeen words fill the buffer; the eighteenth waits for room.
        for (int i = 0; i < 13; i++) xfer(8'h80, 1'b0);
        xfer(8'h81, 1'b0);
        xfer(8'h82, 1'b0);
        xfer(8'h83, 1'b0);
        xfer(8'h85, 1'b0);
        xfer(8'h81, 1'b1);
        drain();
        $display("test done: buffer");
        end_of_test();
    end
    // Watchdog: the tests need about 7500 cycles.
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
